// ---- hdl/cpci_cfg.svh ----
// Constants for the card personality-change sequencer: register map,
// field positions, reset values and timing counts.
// Assumes a 10 MHz mclk; every count is derived from the period below.
`ifndef CPCI_CFG_SVH
`define CPCI_CFG_SVH

`define CPCI_CLK_PERIOD_NS   100
// Least wait from the configuration write to the pin switch
`define CPCI_SWITCH_MIN_NS   10000
`define CPCI_SWITCH_CYC ((`CPCI_SWITCH_MIN_NS + `CPCI_CLK_PERIOD_NS - 1) / `CPCI_CLK_PERIOD_NS)
// Longest time from reset release to ready high
`define CPCI_READY_MAX_S     5
`define CPCI_READY_MAX_CYC   ((`CPCI_READY_MAX_S * 64'd1000000000) / `CPCI_CLK_PERIOD_NS)

// Register offsets (word index on the plain register port)
`define CPCI_OFS_COR         4'h0
`define CPCI_OFS_DAT_CS      4'h1
`define CPCI_OFS_EXT_CS      4'h2
`define CPCI_OFS_SEQ_STAT    4'h3

// Channel control/status fields
`define CPCI_CS_RS_BIT       3
`define CPCI_CS_IIR_BIT      4
`define CPCI_CS_FR_BIT       6

// Sequence status fields
`define CPCI_ST_PERS_BIT     0
`define CPCI_ST_READY_BIT    1
`define CPCI_ST_LINK_BIT     2

`define CPCI_COR_RESET       8'h00

`endif

// ---- hdl/cpci_pkg.sv ----
// Types shared by the personality-change sequencer and its timer.
`default_nettype none

package cpci_pkg;

  typedef enum logic [4:0] {
    CPCI_S_HRST   = 5'b0_0001,
    CPCI_S_INIT   = 5'b0_0010,
    CPCI_S_UNCFG  = 5'b0_0100,
    CPCI_S_SWITCH = 5'b0_1000,
    CPCI_S_ACTIVE = 5'b1_0000
  } cpci_state_e;

  typedef logic [7:0] cpci_byte_t;

endpackage : cpci_pkg

`default_nettype wire

// ---- hdl/cpci_tmr_if.sv ----
// Carrier between the sequencer and its down-counting timer.
// Assumes a single clock shared by both ends.
`timescale 1ns/1ns
`default_nettype none

interface cpci_tmr_if #(
  parameter int W = 26
);
  logic         load;
  logic [W-1:0] load_val;
  logic         expired;

  modport owner (output load, output load_val, input expired);
  modport timer (input load, input load_val, output expired);
endinterface : cpci_tmr_if

`default_nettype wire

// ---- hdl/cpci_timer.sv ----
// Down counter: load sets the count, expired is high once it reaches zero.
// Assumes the owner raises load in the cycle it enters the timed state.
`timescale 1ns/1ns
`default_nettype none

module cpci_timer
  import cpci_pkg::*;
#(
  parameter int W = 26
) (
  input  wire logic mclk,
  input  wire logic resetn,
  cpci_tmr_if.timer tmr
);

  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    if (tmr.load) begin
      cnt_nxt = tmr.load_val;
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - W'(1);
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign tmr.expired = (cnt_r == '0);

endmodule : cpci_timer

`default_nettype wire

// ---- hdl/cpci_seq.sv ----
// Card-side interface initialization and personality-change sequencer.
// Assumes host pins arrive synchronous to mclk and card firmware reports
// internal-init and communication readiness as levels.
//
// Overview of operation
// - No link data units go out until the soft reset sequence is done.
// - Only the configuration option register of the function set exists.
// - Configuration option register reachable only before the personality change.
// - Host writes the table index to it; that write commands the change.
// - Ready goes low within 10 usec of reset release.
// - Until configured the card acts as an unconfigured memory-only module.
// - Ready goes high after internal init, no later than 5 seconds.
// - Pins switch no sooner than 10 usec after the configuration write.
// - Free/ready stays low until the card can really communicate.
// - Soft reset bit in either channel closes sessions, returns to post-change.
//
// The address map and the plain strobed port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "cpci_cfg.svh"

module cpci_seq
  import cpci_pkg::*;
#(
  parameter cpci_byte_t CFG_INDEX  = 8'h25,
  parameter int         TMR_W      = 26,
  parameter int         READY_MAX  = int'(`CPCI_READY_MAX_CYC),
  parameter int         SWITCH_CYC = `CPCI_SWITCH_CYC
) (
  input  wire logic       mclk,
  input  wire logic       resetn,
  input  wire logic       card_reset,
  input  wire logic       int_init_done,
  input  wire logic       comm_ready,
  input  wire logic       reinit_req,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_we,
  input  wire logic       reg_re,
  output logic      [7:0] reg_rdata,
  output logic            ready,
  output logic            mem_only_mode,
  output logic            oob_pins_en,
  output logic            ts_pins_en,
  output logic            link_tx_allow,
  output logic            sessions_close,
  output logic            dat_flush,
  output logic            ext_flush
);

  ////////////////////////////////////////////////////////////////////////
  // Channel status word, built the same way for both channels
  function automatic cpci_byte_t cs_pack(input logic rs, input logic reinit_request_flag,
                                         input logic fr);
    cpci_byte_t w;
    w = 8'h00;
    w[`CPCI_CS_RS_BIT]  = rs;
    w[`CPCI_CS_IIR_BIT] = reinit_request_flag;
    w[`CPCI_CS_FR_BIT]  = fr;
    return w;
  endfunction : cs_pack

  cpci_tmr_if #(.W(TMR_W)) tmr ();

  cpci_timer #(.W(TMR_W)) u_timer (
    .mclk   (mclk),
    .resetn (resetn),
    .tmr    (tmr)
  );

  ////////////////////////////////////////////////////////////////////////
  // State
  cpci_state_e state_r,  state_nxt;
  cpci_byte_t  cor_r,    cor_nxt;
  logic [1:0]  rs_r,     rs_nxt;
  logic [1:0]  iir_r,    iir_nxt;
  logic [1:0]  fr_r,     fr_nxt;
  cpci_byte_t  rdata_r,  rdata_nxt;
  logic        ready_r,  ready_nxt;
  logic        pins_r,   pins_nxt;
  logic        sdone_r,  sdone_nxt;
  logic        link_r,   link_nxt;
  logic        close_r,  close_nxt;
  logic [1:0]  flush_r,  flush_nxt;

  logic wr_cor, wr_dat, wr_ext, rs_rise_any;

  always_comb begin
    wr_cor = reg_we && (reg_addr == `CPCI_OFS_COR);
    wr_dat = reg_we && (reg_addr == `CPCI_OFS_DAT_CS);
    wr_ext = reg_we && (reg_addr == `CPCI_OFS_EXT_CS);
    rs_rise_any = 1'b0;
    state_nxt    = state_r;
    cor_nxt      = cor_r;
    rs_nxt       = rs_r;
    iir_nxt      = iir_r;
    fr_nxt       = fr_r;
    ready_nxt    = ready_r;
    pins_nxt     = pins_r;
    sdone_nxt    = sdone_r;
    close_nxt    = 1'b0;
    flush_nxt    = 2'b00;
    tmr.load     = 1'b0;
    tmr.load_val = TMR_W'(READY_MAX);

    case (state_r)
      CPCI_S_HRST: begin
        // Ready held low right through reset, so it is low at release
        ready_nxt = 1'b0;
        if (!card_reset) begin
          state_nxt    = CPCI_S_INIT;
          tmr.load     = 1'b1;
          tmr.load_val = TMR_W'(READY_MAX);
        end
      end
      CPCI_S_INIT: begin
        // Watchdog forces ready if firmware never reports done
        if (int_init_done || tmr.expired) begin
          state_nxt = CPCI_S_UNCFG;
          ready_nxt = 1'b1;
        end
      end
      CPCI_S_UNCFG: begin
        if (wr_cor) begin
          cor_nxt = reg_wdata;
          // Only the matching table index starts the change
          if (reg_wdata == CFG_INDEX) begin
            state_nxt    = CPCI_S_SWITCH;
            tmr.load     = 1'b1;
            tmr.load_val = TMR_W'(SWITCH_CYC);
          end
        end
      end
      CPCI_S_SWITCH: begin
        if (tmr.expired) begin
          state_nxt = CPCI_S_ACTIVE;
          pins_nxt  = 1'b1;
        end
      end
      CPCI_S_ACTIVE: begin
        if (wr_dat) begin
          rs_nxt[0] = reg_wdata[`CPCI_CS_RS_BIT];
        end
        if (wr_ext) begin
          rs_nxt[1] = reg_wdata[`CPCI_CS_RS_BIT];
        end
        rs_rise_any = |(rs_nxt & ~rs_r);
        if (rs_rise_any) begin
          close_nxt = 1'b1;
          iir_nxt   = 2'b00;
        end
        // Either channel's soft reset drops both back to post-change
        if (|rs_nxt) begin
          fr_nxt = 2'b00;
        end
        flush_nxt = rs_r & ~rs_nxt;
        // One completed channel reset is needed before any link data flows
        if (|(rs_r & ~rs_nxt)) begin
          sdone_nxt = 1'b1;
        end else if (rs_rise_any) begin
          sdone_nxt = 1'b0;
        end
        // Free/ready only once firmware can talk and no reset is pending
        if (comm_ready && !(|rs_r) && !(|rs_nxt)) begin
          fr_nxt = 2'b11;
        end
      end
      default: begin
        state_nxt = CPCI_S_HRST;
      end
    endcase

    // A request in the same cycle as the clearing write still lands
    if (reinit_req && (state_r == CPCI_S_ACTIVE)) begin
      iir_nxt = 2'b11;
    end

    // Hard reset overrides everything and releases the pins
    if (card_reset) begin
      state_nxt = CPCI_S_HRST;
      cor_nxt   = `CPCI_COR_RESET;
      rs_nxt    = 2'b00;
      iir_nxt   = 2'b00;
      fr_nxt    = 2'b00;
      ready_nxt = 1'b0;
      pins_nxt  = 1'b0;
      sdone_nxt = 1'b0;
      close_nxt = 1'b0;
      flush_nxt = 2'b00;
    end

    // Link data only after the soft reset sequence completes
    link_nxt = (state_nxt == CPCI_S_ACTIVE) && !(|rs_nxt)
               && (&fr_nxt) && !(|iir_nxt) && sdone_nxt;
  end

  ////////////////////////////////////////////////////////////////////////
  // Read path: data stand in the cycle after the strobe
  always_comb begin
    rdata_nxt = 8'h00;
    if (reg_re) begin
      case (reg_addr)
        // Option register vanishes once the change has happened
        `CPCI_OFS_COR: begin
          if (state_r != CPCI_S_ACTIVE) begin
            rdata_nxt = cor_r;
          end
        end
        `CPCI_OFS_DAT_CS: begin
          rdata_nxt = cs_pack(rs_r[0], iir_r[0], fr_r[0]);
        end
        `CPCI_OFS_EXT_CS: begin
          rdata_nxt = cs_pack(rs_r[1], iir_r[1], fr_r[1]);
        end
        `CPCI_OFS_SEQ_STAT: begin
          rdata_nxt[`CPCI_ST_PERS_BIT]  = pins_r;
          rdata_nxt[`CPCI_ST_READY_BIT] = ready_r;
          rdata_nxt[`CPCI_ST_LINK_BIT]  = link_r;
        end
        // Other function registers are absent and read zero
        default: begin
          rdata_nxt = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_r <= CPCI_S_HRST;
      cor_r   <= `CPCI_COR_RESET;
      rs_r    <= 2'b00;
      iir_r   <= 2'b00;
      fr_r    <= 2'b00;
      rdata_r <= 8'h00;
      ready_r <= 1'b0;
      pins_r  <= 1'b0;
      sdone_r <= 1'b0;
      link_r  <= 1'b0;
      close_r <= 1'b0;
      flush_r <= 2'b00;
    end else begin
      state_r <= state_nxt;
      cor_r   <= cor_nxt;
      rs_r    <= rs_nxt;
      iir_r   <= iir_nxt;
      fr_r    <= fr_nxt;
      rdata_r <= rdata_nxt;
      ready_r <= ready_nxt;
      pins_r  <= pins_nxt;
      sdone_r <= sdone_nxt;
      link_r  <= link_nxt;
      close_r <= close_nxt;
      flush_r <= flush_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  assign reg_rdata      = rdata_r;
  assign ready          = ready_r;
  assign mem_only_mode  = !pins_r;
  assign oob_pins_en    = pins_r;
  assign ts_pins_en     = pins_r;
  assign link_tx_allow  = link_r;
  assign sessions_close = close_r;
  assign dat_flush      = flush_r[0];
  assign ext_flush      = flush_r[1];

endmodule : cpci_seq

`default_nettype wire

// ---- dv/cpci_seq_props.sv ----
// Port checker for the personality-change sequencer.
// Bound to cpci_seq; one clock, async active-low reset.
`timescale 1ns/1ns
`default_nettype none
////////////////////////////////////////
module cpci_seq_props #(
  parameter int         SWITCH_CYC = 100,
  parameter logic [7:0] CFG_INDEX  = 8'h25
) (
  input wire logic       mclk,
  input wire logic       resetn,
  input wire logic       card_reset,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_we,
  input wire logic       reg_re,
  input wire logic [7:0] reg_rdata,
  input wire logic       ready,
  input wire logic       mem_only_mode,
  input wire logic       oob_pins_en,
  input wire logic       ts_pins_en,
  input wire logic       link_tx_allow,
  input wire logic       sessions_close,
  input wire logic       dat_flush
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  // Cycles since the switching write; saturates so old writes never match
  logic [7:0] sw_cnt_r;
  logic [7:0] sw_cnt_nxt;
  always_comb begin
    sw_cnt_nxt = (sw_cnt_r == 8'hff) ? sw_cnt_r : sw_cnt_r + 8'h01;
    if (reg_we && reg_addr == 4'h0 && reg_wdata == CFG_INDEX && ready && mem_only_mode) begin
      sw_cnt_nxt = 8'h01;
    end
  end
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sw_cnt_r <= 8'hff;
    end else begin
      sw_cnt_r <= sw_cnt_nxt;
    end
  end
  chk_ready_drop: assert property (card_reset |=> !ready)
    else $error("ready high after slot reset");
  chk_hard_unconfig: assert property (card_reset |=> mem_only_mode && !oob_pins_en)
    else $error("slot reset left card configured");
  chk_pin_pair: assert property (
    oob_pins_en == ts_pins_en && mem_only_mode != oob_pins_en)
    else $error("pin functions disagree");
  chk_switch_time: assert property (
    $rose(oob_pins_en) |-> sw_cnt_r == 8'(SWITCH_CYC + 2))
    else $error("pin switch at wrong time");
  chk_ready_hold: assert property (ready && !card_reset |=> ready)
    else $error("ready dropped without slot reset");
  chk_close_cause: assert property (
    sessions_close |-> $past(reg_we) && ($past(reg_wdata) & 8'h08) != 8'h00)
    else $error("session close without soft reset write");
  chk_close_link: assert property (sessions_close |-> !link_tx_allow)
    else $error("link open while closing");
  chk_flush_dat: assert property (dat_flush |-> $past(reg_we) && $past(reg_addr) == 4'h1)
    else $error("data flush without write");
  chk_cor_gone: assert property (
    reg_re && reg_addr == 4'h0 && oob_pins_en |=> reg_rdata == 8'h00)
    else $error("option register visible after change");
  chk_mem_link: assert property (mem_only_mode |-> !link_tx_allow)
    else $error("link open while unconfigured");
  cover property ($rose(oob_pins_en));
  cover property (sessions_close);
  cover property (dat_flush);
endmodule : cpci_seq_props
bind cpci_seq cpci_seq_props #(.SWITCH_CYC(SWITCH_CYC), .CFG_INDEX(CFG_INDEX)) props_inst (
  .mclk, .resetn, .card_reset, .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata,
  .ready, .mem_only_mode, .oob_pins_en, .ts_pins_en, .link_tx_allow, .sessions_close,
  .dat_flush);
`default_nettype wire

// ---- dv/cpci_host.sv ----
// Host slot-master model: register cycles, hard slot reset, ready wait.
// Changes its outputs only just after mclk rising edges.
`timescale 1ns/1ns
`default_nettype none
////////////////////////////////////////
module cpci_host #(
  parameter int RST_CYC  = 100,
  parameter int RDY_WAIT = 200000
) (
  input  wire logic       mclk,
  input  wire logic       ready,
  input  wire logic [7:0] reg_rdata,
  output var  logic       card_reset,
  output var  logic [3:0] reg_addr,
  output var  logic [7:0] reg_wdata,
  output var  logic       reg_we,
  output var  logic       reg_re
);
  initial begin
    card_reset = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_we = 1'b0;
    reg_re = 1'b0;
  end
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge mclk);
    reg_we <= 1'b0;
    // Released lines flip so a stale value can never pass
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge mclk);
    reg_re <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask : rd
  task automatic hard_reset();
    @(posedge mclk);
    card_reset <= 1'b1;
    repeat (RST_CYC) @(posedge mclk);
    card_reset <= 1'b0;
  endtask : hard_reset
  task automatic wait_rdy(input int lim, output bit ok);
    repeat (RDY_WAIT) @(posedge mclk);
    for (int i = 0; i < lim && ready !== 1'b1; i++) @(posedge mclk);
    ok = (ready === 1'b1);
  endtask : wait_rdy
endmodule : cpci_host
`default_nettype wire

// ---- dv/tb_top.sv ----
// Bench for the personality-change sequencer.
// Firmware levels come from here; the slot side from the host model.
`timescale 1ns/1ns
`default_nettype none
////////////////////////////////////////
module tb_top;
  localparam int         RDY_MAX = 200;
  localparam int         SW_CYC  = 10;
  localparam logic [7:0] IDX     = 8'h3c;
  logic       mclk = 1'b0;
  logic       resetn = 1'b0;
  logic       int_init_done = 1'b0;
  logic       comm_ready = 1'b0;
  logic       reinit_req = 1'b0;
  logic       card_reset, reg_we, reg_re, ready, mem_only_mode, oob_pins_en, ts_pins_en;
  logic       link_tx_allow, sessions_close, dat_flush, ext_flush;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rdat;
  logic [11:0] rows [6] = '{12'h000, 12'h100, 12'h200, 12'h302, 12'h400, 12'hf00};
  int         err_total = 0;
  int         n_tests = 0;
  int         cyc = 0;
  bit         ok;
  cpci_seq #(.CFG_INDEX(IDX), .READY_MAX(RDY_MAX), .SWITCH_CYC(SW_CYC)) cpci_seq_inst (
    .mclk, .resetn, .card_reset, .int_init_done, .comm_ready, .reinit_req, .reg_addr,
    .reg_wdata, .reg_we, .reg_re, .reg_rdata, .ready, .mem_only_mode, .oob_pins_en,
    .ts_pins_en, .link_tx_allow, .sessions_close, .dat_flush, .ext_flush);
  cpci_host #(.RDY_WAIT(20)) cpci_host_inst (
    .mclk, .ready, .reg_rdata, .card_reset, .reg_addr, .reg_wdata, .reg_we, .reg_re);
  always #50 mclk = ~mclk;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : print_verdict
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      print_verdict();
    end
  end
  initial begin
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    chk({6'h00, ready, mem_only_mode}, 8'h01);
    // Firmware stays silent, so only the watchdog can raise ready
    cpci_host_inst.wait_rdy(RDY_MAX, ok);
    chk({7'h00, ok}, 8'h01);
    foreach (rows[i]) begin
      cpci_host_inst.rd(rows[i][11:8], rdat);
      chk(rdat, rows[i][7:0]);
    end
    cpci_host_inst.wr(4'h0, 8'h5a);
    cpci_host_inst.rd(4'h0, rdat);
    chk(rdat, 8'h5a);
    repeat (SW_CYC + 4) @(posedge mclk);
    #1;
    chk({7'h00, mem_only_mode}, 8'h01);
    cpci_host_inst.wr(4'h0, IDX);
    // Firmware ready before the switch: link must still wait for a soft reset
    comm_ready <= 1'b1;
    repeat (SW_CYC) @(posedge mclk);
    #1;
    chk({5'h00, oob_pins_en, ts_pins_en, mem_only_mode}, 8'h01);
    @(posedge mclk);
    #1;
    chk({5'h00, oob_pins_en, ts_pins_en, mem_only_mode}, 8'h06);
    cpci_host_inst.rd(4'h1, rdat);
    chk({rdat[7:1], link_tx_allow}, 8'h40);
    cpci_host_inst.wr(4'h0, 8'h00);
    cpci_host_inst.rd(4'h0, rdat);
    chk(rdat, 8'h00);
    @(posedge mclk);
    reinit_req <= 1'b1;
    @(posedge mclk);
    reinit_req <= 1'b0;
    cpci_host_inst.rd(4'h2, rdat);
    chk(rdat, 8'h50);
    for (int ch = 1; ch <= 2; ch++) begin
      cpci_host_inst.wr(4'(ch), 8'h08);
      #1;
      chk({6'h00, sessions_close, link_tx_allow}, 8'h02);
      repeat (400) @(posedge mclk);
      cpci_host_inst.wr(4'(ch), 8'h00);
      #1;
      chk({6'h00, dat_flush, ext_flush}, (ch == 1) ? 8'h02 : 8'h01);
      @(posedge mclk);
      #1;
      chk({7'h00, link_tx_allow}, 8'h01);
      cpci_host_inst.rd(4'(ch), rdat);
      chk(rdat, 8'h40);
    end
    cpci_host_inst.rd(4'h3, rdat);
    chk(rdat, 8'h07);
    cpci_host_inst.hard_reset();
    #1;
    chk({5'h00, ready, mem_only_mode, link_tx_allow}, 8'h02);
    @(posedge mclk);
    int_init_done <= 1'b1;
    cpci_host_inst.wait_rdy(4, ok);
    chk({7'h00, ok}, 8'h01);
    cpci_host_inst.wr(4'h0, 8'h11);
    cpci_host_inst.rd(4'h0, rdat);
    chk(rdat, 8'h11);
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
